// ==== rtl/rsic_radio_ctrl.sv ====
// Contract
// - each one-byte strobe code 00 to 04 starts its own radio control sequence
// - code 00 turns synth on, calibrating first from idle if autocal 01; rx+cca waits synth-only
// - code 01 calibrates the synth then turns it off, allowed from idle or synth on
// - code 02 enters receive, calibrating first from idle when autocal is 01
// - code 03 from idle enters transmit, calibrating first when autocal is 01
// - transmit strobe during receive with cca enters transmit only on clear channel
// - code 04 returns to idle, synth off; all other codes do nothing
// - idle strobe discards pending strobes; later strobes ignored until idle reached
// - data buffer has its own port; configuration and status are mapped registers
// - two interrupt outputs: data transfer vector and general radio event vector
// - data transfer interrupt only for rx byte ready or tx register free, including on entry to transmit
// - radio event vector merges all events enabled by the event mask
// - radio events trigger on rising edges of their status only
// - data transfer flag set on waiting rx byte or free tx register
// - no data transfer flag in transmit before a transmit strobe; cpu writes after
// - eight event flags: tx underflow down to sync word detected
// - masked event sets cpu event flag; request only with event irq enable
// - data transfer request only when its interrupt enable is one
`timescale 1ns/100ps
`default_nettype none
module rsic_radio_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] radio_event_status,
	input wire logic channel_clear,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic tx_byte_taken,
	output logic synth_on,
	output logic rx_on,
	output logic tx_on,
	output logic calibrating,
	output logic [7:0] tx_byte,
	output logic tx_byte_valid,
	output logic irq_data_transfer,
	output logic irq_radio_event
);
	// ************************************************************
	// declarations
	// ************************************************************
	rsic_pkg::rsic_state_e state_reg;
	rsic_pkg::rsic_state_e cal_target_reg;
	rsic_pkg::rsic_state_e dec_target;
	logic [7:0] seq_cnt_reg;
	logic dec_cal;
	logic [4:0] config_reg;
	logic [7:0] event_mask_reg;
	logic [7:0] rx_data_reg;
	logic [7:0] tx_data_reg;
	logic tx_full_reg;
	logic tx_space_prev_reg;
	logic dt_flag_reg;
	logic cpu_event_reg;
	logic irq_dt_reg;
	logic irq_re_reg;
	logic [31:0] prdata_reg;
	logic wr_access;
	logic rd_setup;
	logic addr_ok;
	logic strobe_wr;
	logic is_idle_cmd;
	logic flush;
	logic push_valid;
	logic pop;
	logic seq_busy;
	logic q_empty;
	logic [7:0] q_head;
	logic [rsic_pkg::QUEUE_AW:0] q_count;
	logic [7:0] ev_flags;
	logic [7:0] ev_set;
	logic ev_clr_we;
	logic [1:0] autocal;
	logic cca_en;
	logic dt_ie;
	logic re_ie;
	logic rx_take;
	logic tx_space;
	logic tx_space_rise;
	logic dt_clear;
	logic cpu_clear;
	logic [31:0] rd_mux;

	assign autocal = config_reg[rsic_pkg::CFG_AUTOCAL_LSB +: 2];
	assign cca_en = config_reg[rsic_pkg::CFG_CCA_BIT];
	assign dt_ie = config_reg[rsic_pkg::CFG_DT_IE_BIT];
	assign re_ie = config_reg[rsic_pkg::CFG_RE_IE_BIT];

	// ************************************************************
	// apb slave: zero wait states, read data latched in setup
	// ************************************************************
	assign pready = penable;
	assign wr_access = psel && penable && pwrite && addr_ok;
	assign rd_setup = psel && !penable && !pwrite;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_reg;

	always_comb begin
		addr_ok = 1'b1;
		rd_mux = 32'h00000000;
		unique case (paddr)
			rsic_pkg::ADDR_STROBE: begin
				rd_mux = 32'h00000000;
			end
			rsic_pkg::ADDR_CONFIG: begin
				rd_mux[4:0] = config_reg;
			end
			rsic_pkg::ADDR_STATUS: begin
				rd_mux[rsic_pkg::STAT_STATE_LSB +: 3] = state_reg;
				rd_mux[rsic_pkg::STAT_COUNT_LSB +: rsic_pkg::QUEUE_AW+1] = q_count;
				rd_mux[rsic_pkg::STAT_TXFULL_BIT] = tx_full_reg;
			end
			rsic_pkg::ADDR_RADIO_DATA: begin
				rd_mux[7:0] = rx_data_reg;
			end
			rsic_pkg::ADDR_TIMER_CTRL: begin
				rd_mux[rsic_pkg::TIMER_CONTROL_FLAGS_DT_FLAG_BIT] = dt_flag_reg;
			end
			rsic_pkg::ADDR_EVENT_FLAGS: begin
				rd_mux[7:0] = ev_flags;
			end
			rsic_pkg::ADDR_EVENT_MASK: begin
				rd_mux[7:0] = event_mask_reg;
			end
			rsic_pkg::ADDR_CPU_EVENT: begin
				rd_mux[rsic_pkg::CPU_RE_FLAG_BIT] = cpu_event_reg;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (rd_setup) begin
			prdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_reg <= rsic_pkg::CFG_RESET;
			event_mask_reg <= rsic_pkg::EVENT_MASK_RESET;
		end else if (wr_access) begin
			if (paddr == rsic_pkg::ADDR_CONFIG) begin
				config_reg <= pwdata[4:0];
			end
			if (paddr == rsic_pkg::ADDR_EVENT_MASK) begin
				event_mask_reg <= pwdata[7:0];
			end
		end
	end

	// ************************************************************
	// strobe intake and backlog
	// ************************************************************
	assign strobe_wr = wr_access && (paddr == rsic_pkg::ADDR_STROBE);
	assign is_idle_cmd = (pwdata[7:0] == rsic_pkg::CMD_IDLE);
	// the idle strobe bypasses the backlog so it can cut a long calibration short
	assign flush = strobe_wr && is_idle_cmd;
	assign push_valid = strobe_wr && !is_idle_cmd && (state_reg != rsic_pkg::ST_GOING_IDLE);
	assign seq_busy = (state_reg == rsic_pkg::ST_CAL) || (state_reg == rsic_pkg::ST_GOING_IDLE);
	assign pop = !q_empty && !seq_busy && !flush;

	rsic_strobe_queue u_queue (
		.pclk(pclk),
		.presetn(presetn),
		.push_valid(push_valid),
		.push_data(pwdata[7:0]),
		.pop(pop),
		.flush(flush),
		.empty(q_empty),
		.full(),
		.head(q_head),
		.count(q_count)
	);

	// ************************************************************
	// strobe decode
	// ************************************************************
	always_comb begin
		dec_cal = 1'b0;
		dec_target = state_reg;
		if (q_head == rsic_pkg::CMD_SYNTH_ON) begin
			dec_target = rsic_pkg::ST_SYNTH;
			dec_cal = (state_reg == rsic_pkg::ST_IDLE) && (autocal == rsic_pkg::AUTOCAL_ON_START);
		end else if (q_head == rsic_pkg::CMD_CALIBRATE) begin
			if (state_reg == rsic_pkg::ST_IDLE || state_reg == rsic_pkg::ST_SYNTH) begin
				dec_cal = 1'b1;
				dec_target = rsic_pkg::ST_IDLE;
			end
		end else if (q_head == rsic_pkg::CMD_RECEIVE) begin
			dec_target = rsic_pkg::ST_RX;
			dec_cal = (state_reg == rsic_pkg::ST_IDLE) && (autocal == rsic_pkg::AUTOCAL_ON_START);
		end else if (q_head == rsic_pkg::CMD_TRANSMIT) begin
			if (state_reg == rsic_pkg::ST_RX && cca_en) begin
				dec_target = channel_clear ? rsic_pkg::ST_TX : rsic_pkg::ST_RX;
			end else begin
				dec_target = rsic_pkg::ST_TX;
				dec_cal = (state_reg == rsic_pkg::ST_IDLE) && (autocal == rsic_pkg::AUTOCAL_ON_START);
			end
		end
	end

	// ************************************************************
	// radio sequencer
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= rsic_pkg::ST_IDLE;
			cal_target_reg <= rsic_pkg::ST_IDLE;
			seq_cnt_reg <= 8'h00;
		end else if (flush) begin
			if (state_reg != rsic_pkg::ST_IDLE) begin
				state_reg <= rsic_pkg::ST_GOING_IDLE;
				seq_cnt_reg <= rsic_pkg::IDLE_CYCLES;
			end
		end else begin
			unique case (state_reg)
				rsic_pkg::ST_CAL, rsic_pkg::ST_GOING_IDLE: begin
					if (seq_cnt_reg == 8'h01) begin
						state_reg <= (state_reg == rsic_pkg::ST_CAL) ? cal_target_reg
							: rsic_pkg::ST_IDLE;
					end
					seq_cnt_reg <= seq_cnt_reg - 8'h01;
				end
				rsic_pkg::ST_IDLE, rsic_pkg::ST_SYNTH, rsic_pkg::ST_RX, rsic_pkg::ST_TX: begin
					if (pop && dec_cal) begin
						state_reg <= rsic_pkg::ST_CAL;
						cal_target_reg <= dec_target;
						seq_cnt_reg <= rsic_pkg::CAL_CYCLES;
					end else if (pop) begin
						state_reg <= dec_target;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			synth_on <= 1'b0;
			rx_on <= 1'b0;
			tx_on <= 1'b0;
			calibrating <= 1'b0;
		end else begin
			synth_on <= (state_reg != rsic_pkg::ST_IDLE) && (state_reg != rsic_pkg::ST_GOING_IDLE);
			rx_on <= (state_reg == rsic_pkg::ST_RX);
			tx_on <= (state_reg == rsic_pkg::ST_TX);
			calibrating <= (state_reg == rsic_pkg::ST_CAL);
		end
	end

	// ************************************************************
	// radio data register and data transfer flag
	// ************************************************************
	assign rx_take = rx_byte_valid && (state_reg == rsic_pkg::ST_RX);
	// only a transmit state opens the tx register, so no flag before the strobe
	assign tx_space = (state_reg == rsic_pkg::ST_TX) && !tx_full_reg;
	assign tx_space_rise = tx_space && !tx_space_prev_reg;
	assign dt_clear = wr_access && (paddr == rsic_pkg::ADDR_TIMER_CTRL)
		&& !pwdata[rsic_pkg::TIMER_CONTROL_FLAGS_DT_FLAG_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data_reg <= 8'h00;
		end else if (rx_take) begin
			rx_data_reg <= rx_byte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data_reg <= 8'h00;
			tx_full_reg <= 1'b0;
		end else if (state_reg != rsic_pkg::ST_TX) begin
			tx_full_reg <= 1'b0;
		end else if (wr_access && paddr == rsic_pkg::ADDR_RADIO_DATA && !tx_full_reg) begin
			tx_data_reg <= pwdata[7:0];
			tx_full_reg <= 1'b1;
		end else if (tx_byte_taken) begin
			tx_full_reg <= 1'b0;
		end
	end

	assign tx_byte = tx_data_reg;
	assign tx_byte_valid = tx_full_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_space_prev_reg <= 1'b0;
			dt_flag_reg <= 1'b0;
		end else begin
			tx_space_prev_reg <= tx_space;
			// set beats a clear in the same cycle, so no byte goes unnoticed
			if (rx_take || tx_space_rise) begin
				dt_flag_reg <= 1'b1;
			end else if (dt_clear) begin
				dt_flag_reg <= 1'b0;
			end
		end
	end

	// ************************************************************
	// general radio events
	// ************************************************************
	assign ev_clr_we = wr_access && (paddr == rsic_pkg::ADDR_EVENT_FLAGS);
	assign cpu_clear = wr_access && (paddr == rsic_pkg::ADDR_CPU_EVENT)
		&& !pwdata[rsic_pkg::CPU_RE_FLAG_BIT];

	rsic_event_edges u_edges (
		.pclk(pclk),
		.presetn(presetn),
		.ev_status(radio_event_status),
		.clr_we(ev_clr_we),
		.clr_data(pwdata[7:0]),
		.ev_flags(ev_flags),
		.ev_set(ev_set)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_event_reg <= 1'b0;
		end else if (|(ev_set & event_mask_reg)) begin
			cpu_event_reg <= 1'b1;
		end else if (cpu_clear) begin
			cpu_event_reg <= 1'b0;
		end
	end

	// ************************************************************
	// interrupt outputs: vector 0 data transfer, vector 16 radio events
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_dt_reg <= 1'b0;
			irq_re_reg <= 1'b0;
		end else begin
			irq_dt_reg <= dt_flag_reg && dt_ie;
			irq_re_reg <= cpu_event_reg && re_ie;
		end
	end

	assign irq_data_transfer = irq_dt_reg;
	assign irq_radio_event = irq_re_reg;

	// ************************************************************
	// checks
	// ************************************************************
	chk_idle_flush_queue: assert property (@(posedge pclk) disable iff (!presetn)
		flush |=> q_empty)
		else $error("idle strobe left strobes pending");

	chk_ignore_going_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == rsic_pkg::ST_GOING_IDLE && q_empty) |=> q_empty)
		else $error("strobe taken while heading for idle");

	chk_cal_before_rx: assert property (@(posedge pclk) disable iff (!presetn)
		(pop && q_head == rsic_pkg::CMD_RECEIVE && state_reg == rsic_pkg::ST_IDLE
		&& autocal == rsic_pkg::AUTOCAL_ON_START)
		|=> state_reg == rsic_pkg::ST_CAL ##32 state_reg == rsic_pkg::ST_RX)
		else $error("receive not preceded by calibration");

	chk_tx_busy_channel: assert property (@(posedge pclk) disable iff (!presetn)
		(pop && q_head == rsic_pkg::CMD_TRANSMIT && state_reg == rsic_pkg::ST_RX
		&& cca_en && !channel_clear) |=> state_reg == rsic_pkg::ST_RX)
		else $error("transmit entered on busy channel");

	chk_nop_keeps_state: assert property (@(posedge pclk) disable iff (!presetn)
		(pop && q_head > rsic_pkg::CMD_IDLE) |=> $stable(state_reg))
		else $error("no-op strobe changed state");

	chk_cal_length: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg == rsic_pkg::ST_CAL) |-> ##32 state_reg != rsic_pkg::ST_CAL)
		else $error("calibration length wrong");

	chk_rx_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		rx_take |=> dt_flag_reg ##1 (irq_data_transfer == dt_ie))
		else $error("rx byte did not raise data flag");

	chk_no_flag_before_tx: assert property (@(posedge pclk) disable iff (!presetn)
		(!dt_flag_reg && !rx_take && state_reg != rsic_pkg::ST_TX) |=> !dt_flag_reg)
		else $error("data flag without rx byte or transmit");

	chk_event_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(|(ev_set & event_mask_reg)) |=> cpu_event_reg ##1 (irq_radio_event == re_ie))
		else $error("masked event did not reach radio event irq");

	chk_dt_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!dt_ie |=> !irq_data_transfer)
		else $error("data irq raised while disabled");
endmodule : rsic_radio_ctrl
`default_nettype wire

// ==== shared/rsic_pkg.sv ====
package rsic_pkg;

	// ************************************************************
	// register map, byte addresses on the apb bus
	// ************************************************************
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] ADDR_STROBE = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_RADIO_DATA = 8'h0C;
	localparam logic [7:0] ADDR_TIMER_CTRL = 8'h10;
	localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h14;
	localparam logic [7:0] ADDR_EVENT_MASK = 8'h18;
	localparam logic [7:0] ADDR_CPU_EVENT = 8'h1C;

	// ************************************************************
	// strobe codes and calibration modes
	// ************************************************************
	localparam logic [7:0] CMD_SYNTH_ON = 8'h00;
	localparam logic [7:0] CMD_CALIBRATE = 8'h01;
	localparam logic [7:0] CMD_RECEIVE = 8'h02;
	localparam logic [7:0] CMD_TRANSMIT = 8'h03;
	localparam logic [7:0] CMD_IDLE = 8'h04;
	localparam logic [1:0] AUTOCAL_MANUAL = 2'h0;
	localparam logic [1:0] AUTOCAL_ON_START = 2'h1;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int unsigned CFG_AUTOCAL_LSB = 0;
	localparam int unsigned CFG_CCA_BIT = 2;
	localparam int unsigned CFG_DT_IE_BIT = 3;
	localparam int unsigned CFG_RE_IE_BIT = 4;
	localparam logic [4:0] CFG_RESET = 5'h00;
	localparam int unsigned TIMER_CONTROL_FLAGS_DT_FLAG_BIT = 0;
	localparam int unsigned CPU_RE_FLAG_BIT = 0;
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_COUNT_LSB = 4;
	localparam int unsigned STAT_TXFULL_BIT = 8;
	localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
	localparam int unsigned EVENT_COUNT = 8;
	localparam int unsigned EV_TX_UNDERFLOW_BIT = 7;
	localparam int unsigned EV_RX_OVERFLOW_BIT = 6;

	// ************************************************************
	// sequence timing and strobe backlog
	// ************************************************************
	localparam logic [7:0] CAL_CYCLES = 8'h20;
	localparam logic [7:0] IDLE_CYCLES = 8'h04;
	localparam int unsigned QUEUE_DEPTH = 4;
	localparam int unsigned QUEUE_AW = 2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CAL,
		ST_SYNTH,
		ST_RX,
		ST_TX,
		ST_GOING_IDLE
	} rsic_state_e;

endpackage : rsic_pkg

// ==== rtl/rsic_strobe_queue.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsic_strobe_queue (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic push_valid,
	input wire logic [7:0] push_data,
	input wire logic pop,
	input wire logic flush,
	output logic empty,
	output logic full,
	output logic [7:0] head,
	output logic [rsic_pkg::QUEUE_AW:0] count
);
	logic [7:0] slot_reg [rsic_pkg::QUEUE_DEPTH];
	logic [rsic_pkg::QUEUE_AW-1:0] rd_ptr_reg;
	logic [rsic_pkg::QUEUE_AW-1:0] wr_ptr_reg;
	logic [rsic_pkg::QUEUE_AW:0] count_reg;
	logic do_push;
	logic do_pop;

	// a push into a full backlog is dropped; the cpu sees the count first
	assign empty = (count_reg == '0);
	assign full = (count_reg == (rsic_pkg::QUEUE_AW+1)'(rsic_pkg::QUEUE_DEPTH));
	assign head = slot_reg[rd_ptr_reg];
	assign count = count_reg;
	assign do_push = push_valid && !full && !flush;
	assign do_pop = pop && !empty && !flush;

	always_ff @(posedge pclk) begin
		if (do_push) begin
			slot_reg[wr_ptr_reg] <= push_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			count_reg <= '0;
		end else if (flush) begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (rsic_pkg::QUEUE_AW+1)'(do_push)
				- (rsic_pkg::QUEUE_AW+1)'(do_pop);
		end
	end
endmodule : rsic_strobe_queue
`default_nettype wire

// ==== rtl/rsic_event_edges.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsic_event_edges (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] ev_status,
	input wire logic clr_we,
	input wire logic [7:0] clr_data,
	output logic [7:0] ev_flags,
	output logic [7:0] ev_set
);
	logic [7:0] prev_reg;
	logic [7:0] flag_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= 8'h00;
		end else begin
			prev_reg <= ev_status;
		end
	end

	genvar i;
	generate
		for (i = 0; i < rsic_pkg::EVENT_COUNT; i++) begin : g_ev
			// a level that stays high raises nothing new
			assign ev_set[i] = ev_status[i] && !prev_reg[i];
			// writing zero clears; a fresh edge in that cycle wins
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flag_reg[i] <= 1'b0;
				end else if (ev_set[i]) begin
					flag_reg[i] <= 1'b1;
				end else if (clr_we && !clr_data[i]) begin
					flag_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign ev_flags = flag_reg;

	chk_rise_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(ev_status[0] && !prev_reg[0]) |=> flag_reg[0])
		else $error("event edge did not set its flag");
endmodule : rsic_event_edges
`default_nettype wire

// ==== tb/rsic_radio_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsic_radio_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rx_go,
	input wire logic [7:0] rx_val,
	input wire logic tx_byte_valid,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic tx_byte_taken
);
	// ********
	// radio core side
	// ********
	logic [1:0] wait_cnt;
	// data toggles between bytes so a stale byte never passes for a new one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_byte_valid <= 1'h0;
			rx_byte <= 8'h00;
		end else begin
			rx_byte_valid <= rx_go;
			rx_byte <= rx_go ? rx_val : ~rx_byte;
		end
	end
	// slow consumer, holds each tx byte a few cycles before taking it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt <= 2'h0;
			tx_byte_taken <= 1'h0;
		end else begin
			tx_byte_taken <= 1'h0;
			if (tx_byte_valid && !tx_byte_taken) begin
				wait_cnt <= wait_cnt + 2'h1;
				tx_byte_taken <= (wait_cnt == 2'h3);
			end else begin
				wait_cnt <= 2'h0;
			end
		end
	end
endmodule : rsic_radio_model
`default_nettype wire

// ==== tb/rsic_radio_ctrl_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module rsic_radio_ctrl_bench;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] ev = 8'h00;
	logic clr = 1'h0;
	logic rx_go = 1'h0;
	logic [7:0] rx_val = 8'h00;
	logic [31:0] prdata, rd, v;
	logic [31:0] seed = 32'h2C34BEFA;
	logic pready, pslverr, err, rx_byte_valid, tx_byte_taken, synth_on, rx_on, tx_on;
	logic calibrating, tx_byte_valid, irq_dt, irq_re;
	logic [7:0] rx_byte, tx_byte;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	rsic_radio_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .radio_event_status(ev), .channel_clear(clr),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_byte_taken(tx_byte_taken),
		.synth_on(synth_on), .rx_on(rx_on), .tx_on(tx_on), .calibrating(calibrating),
		.tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .irq_data_transfer(irq_dt),
		.irq_radio_event(irq_re));
	rsic_radio_model model (.pclk(pclk), .presetn(presetn), .rx_go(rx_go), .rx_val(rx_val),
		.tx_byte_valid(tx_byte_valid), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
		.tx_byte_taken(tx_byte_taken));
	// ********
	// helpers
	// ********
	always #5 pclk = ~pclk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [2:0] nxt(input logic [7:0] c, input logic [2:0] s, input logic cl);
		if (c > rsic_pkg::CMD_IDLE) return s;
		if (c == rsic_pkg::CMD_TRANSMIT && s == rsic_pkg::ST_RX && !cl) return s;
		return rsic_pkg::ST_TX;
	endfunction : nxt
	task automatic tally_and_finish();
		if (error_cnt == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// no fixed wait: only the cycle ceiling ends a hung access
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// polls the state field, bounded, then compares
	task automatic st(input logic [2:0] s);
		int i;
		for (i = 0; i < 80; i++) begin
			apb(1'h0, rsic_pkg::ADDR_STATUS, 32'h0);
			if (rd[2:0] === s) break;
		end
		chk(32'(rd[2:0]), 32'(s));
	endtask : st
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	// ********
	// scenarios
	// ********
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, rsic_pkg::ADDR_CONFIG, 32'h0);
		chk(rd, 32'(rsic_pkg::CFG_RESET));
		apb(1'h0, rsic_pkg::ADDR_EVENT_MASK, 32'h0);
		chk(rd, 32'(rsic_pkg::EVENT_MASK_RESET));
		apb(1'h0, 8'h40, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		repeat (4) begin
			v = 32'h5 + xs() % 251;
			apb(1'h1, rsic_pkg::ADDR_STROBE, v);
			st(nxt(v[7:0], rsic_pkg::ST_IDLE, clr));
		end
		apb(1'h1, rsic_pkg::ADDR_CONFIG, 32'h1D);
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'h2);
		st(rsic_pkg::ST_CAL);
		st(rsic_pkg::ST_RX);
		chk(32'(rx_on), 32'h1);
		apb(1'h0, rsic_pkg::ADDR_TIMER_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'h3);
		repeat (3) apb(1'h0, rsic_pkg::ADDR_STATUS, 32'h0);
		chk(32'(rd[2:0]), 32'(nxt(8'h03, rsic_pkg::ST_RX, clr)));
		clr <= 1'h1;
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'h3);
		st(nxt(8'h03, rsic_pkg::ST_RX, 1'h1));
		apb(1'h0, rsic_pkg::ADDR_TIMER_CTRL, 32'h0);
		chk(rd, 32'h1);
		chk(32'(irq_dt), 32'h1);
		chk(32'(tx_on), 32'h1);
		v = xs();
		apb(1'h1, rsic_pkg::ADDR_RADIO_DATA, v);
		#1 chk({tx_byte_valid, tx_byte}, {1'h1, v[7:0]});
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'h4);
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'h2);
		st(rsic_pkg::ST_IDLE);
		apb(1'h0, rsic_pkg::ADDR_STATUS, 32'h0);
		chk({rd[6:0], synth_on}, 8'h00);
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'h1);
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'h2);
		apb(1'h0, rsic_pkg::ADDR_STATUS, 32'h0);
		chk({rd[6:0], calibrating}, 8'h23);
		st(rsic_pkg::ST_RX);
		apb(1'h1, rsic_pkg::ADDR_TIMER_CTRL, 32'h0);
		v = xs();
		rx_val <= v[7:0];
		rx_go <= 1'h1;
		@(posedge pclk) rx_go <= 1'h0;
		apb(1'h0, rsic_pkg::ADDR_TIMER_CTRL, 32'h0);
		chk({rd[30:0], irq_dt}, 32'h3);
		apb(1'h1, rsic_pkg::ADDR_TIMER_CTRL, 32'h0);
		apb(1'h0, rsic_pkg::ADDR_RADIO_DATA, 32'h0);
		chk(rd, 32'(rx_val));
		v = (xs() | 32'h1) & 32'h7F;
		apb(1'h1, rsic_pkg::ADDR_EVENT_MASK, v);
		ev <= 8'h01;
		apb(1'h0, rsic_pkg::ADDR_CPU_EVENT, 32'h0);
		chk({rd[30:0], irq_re}, 32'h3);
		apb(1'h1, rsic_pkg::ADDR_CONFIG, 32'h05);
		apb(1'h1, rsic_pkg::ADDR_EVENT_FLAGS, 32'h0);
		apb(1'h1, rsic_pkg::ADDR_CPU_EVENT, 32'h0);
		ev <= 8'h81;
		apb(1'h0, rsic_pkg::ADDR_EVENT_FLAGS, 32'h0);
		chk(rd, 32'h80);
		apb(1'h0, rsic_pkg::ADDR_CPU_EVENT, 32'h0);
		chk({rd[29:0], irq_re, irq_dt}, 32'h0);
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'(rsic_pkg::CMD_SYNTH_ON));
		st(rsic_pkg::ST_SYNTH);
		chk(32'(synth_on), 32'h1);
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'(rsic_pkg::CMD_IDLE));
		st(rsic_pkg::ST_IDLE);
		apb(1'h1, rsic_pkg::ADDR_STROBE, 32'(rsic_pkg::CMD_TRANSMIT));
		st(rsic_pkg::ST_CAL);
		st(rsic_pkg::ST_TX);
		chk(32'(tx_on), 32'h1);
		tally_and_finish();
	end
endmodule : rsic_radio_ctrl_bench
`default_nettype wire
